/* File: mac_pause_flow_control.sv */
// pause frame generation, receive filtering and transmit throttling
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "pause_fc_defines.svh"
module mac_pause_flow_control
   import pause_fc_pkg::*;
(
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_rstn,
   input  wire logic [`PFC_ADDR_W-1:0] i_addr,
   input  wire logic [31:0]            i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic      [31:0]            o_rdata,
   input  wire logic [`PFC_NQ-1:0]     i_pause_insert,
   input  wire rx_ctrl_frame_s         i_rx_frame,
   input  wire logic                   i_tx_in_frame,
   output logic                        o_rx_fwd,
   output logic                        o_rx_drop,
   output logic [`PFC_NQ-1:0]          o_pause_match,
   output logic [`PFC_NQ-1:0]          o_tx_paused,
   output tx_pause_req_s               o_tx_pause_req
);
   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0]         daddr_low_q;
   logic [15:0]         daddr_high_q;
   logic [31:0]         ctrl_q;
   logic [`PFC_NQ-1:0]  class_en_q;
   logic [15:0]         quanta_q;
   logic [15:0]         holdoff_q;

   wire proc_en   = ctrl_q[`BIT_PROC_EN];
   wire fwd_en    = ctrl_q[`BIT_FWD_EN];
   wire honour    = ctrl_q[`BIT_HONOUR];
   wire prio_mode = ctrl_q[`BIT_PRIO_MODE];
   wire retx_en   = ctrl_q[`BIT_RETX_EN];

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         daddr_low_q  <= 32'h0000_0000;
         daddr_high_q <= 16'h0000;
         ctrl_q       <= `CTRL_RESET;
         class_en_q   <= {`PFC_NQ{1'b1}};
         quanta_q     <= `QUANTA_RESET;
         holdoff_q    <= `HOLDOFF_RESET;
      end else if (i_wr) begin
         unique case (i_addr)
            `OFF_DADDR_LOW:   daddr_low_q  <= i_wdata;
            `OFF_DADDR_HIGH:  daddr_high_q <= i_wdata[15:0];
            `OFF_CTRL:        ctrl_q       <= {27'h0, i_wdata[4:0]};
            `OFF_TX_CLASS_EN: class_en_q   <= i_wdata[`PFC_NQ-1:0];
            `OFF_QUANTA:      quanta_q     <= i_wdata[15:0];
            `OFF_HOLDOFF:     holdoff_q    <= i_wdata[15:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pause request synchroniser: the client request is a level from outside
   logic [`PFC_NQ-1:0] ins_s1_q;
   logic [`PFC_NQ-1:0] ins_s2_q;
   logic [`PFC_NQ-1:0] ins_prev_q;
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ins_s1_q   <= '0;
         ins_s2_q   <= '0;
         ins_prev_q <= '0;
      end else begin
         ins_s1_q   <= i_pause_insert;
         ins_s2_q   <= ins_s1_q;
         ins_prev_q <= ins_s2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit pause generation
   logic [`PFC_NQ-1:0] xoff_pend_q;
   logic [`PFC_NQ-1:0] xon_pend_q;
   logic [15:0]        retx_cnt_q [`PFC_NQ];
   logic [`PFC_NQ-1:0] retx_due;
   logic [`PFC_NQ-1:0] rise;
   logic [`PFC_NQ-1:0] fall;
   tx_gen_state_e      tx_st_q;
   tx_pause_req_s      req_q;

   assign rise = ins_s2_q & ~ins_prev_q & class_en_q;
   assign fall = ~ins_s2_q & ins_prev_q & class_en_q;

   // sends wait for idle link so an outgoing frame is never cut short
   wire         link_free = !i_tx_in_frame;
   wire         send_xoff = (tx_st_q == TX_SEND) && (|xoff_pend_q);
   wire         send_xon  = (tx_st_q == TX_SEND) && !(|xoff_pend_q) && (|xon_pend_q);
   wire [`PFC_NQ-1:0] xoff_done = send_xoff ? xoff_pend_q : '0;
   wire [`PFC_NQ-1:0] xon_done  = send_xon  ? xon_pend_q  : '0;

   for (genvar g = 0; g < `PFC_NQ; g++) begin : g_retx
      assign retx_due[g] = retx_en && ins_s2_q[g] && class_en_q[g]
                           && (retx_cnt_q[g] == 16'h0000) && !xoff_pend_q[g];
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            retx_cnt_q[g] <= 16'h0000;
         end else if (xoff_done[g]) begin
            retx_cnt_q[g] <= holdoff_q;
         end else if (retx_cnt_q[g] != 16'h0000) begin
            retx_cnt_q[g] <= retx_cnt_q[g] - 16'h0001;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         xoff_pend_q <= '0;
         xon_pend_q  <= '0;
      end else begin
         // new requests win over the completion of an older send
         xoff_pend_q <= (xoff_pend_q & ~xoff_done & ~fall) | rise | retx_due;
         xon_pend_q  <= (xon_pend_q & ~xon_done & ~rise) | fall;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_st_q <= TX_IDLE;
      end else begin
         unique case (tx_st_q)
            TX_IDLE: if (|(xoff_pend_q | xon_pend_q)) tx_st_q <= TX_WAIT;
            TX_WAIT: if (link_free) tx_st_q <= TX_SEND;
            TX_SEND: tx_st_q <= TX_IDLE;
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         req_q <= '0;
      end else begin
         req_q.valid     <= send_xoff | send_xon;
         req_q.xon       <= send_xon;
         req_q.class_vec <= send_xoff ? xoff_pend_q : xon_pend_q;
         req_q.quanta    <= send_xon ? 16'h0000 : quanta_q;
      end
   end
   assign o_tx_pause_req = req_q;

   ////////////////////////////////////////////////////////////////////////////
   // receive filtering
   function automatic logic [15:0] time_of(input logic [127:0] t, input int unsigned n);
      time_of = t[n*16 +: 16];
   endfunction

   wire [47:0] cfg_da    = {daddr_high_q, daddr_low_q};
   wire        is_pause  = i_rx_frame.valid && (i_rx_frame.ether_type == `PAUSE_ETYPE)
                           && (i_rx_frame.opcode == (prio_mode ? `OPC_PFC : `OPC_STD));
   wire        addr_hit  = (i_rx_frame.dest_addr == cfg_da)
                           || (i_rx_frame.dest_addr == `MCAST_PAUSE_DA);
   wire        bad_frame = !prio_mode && (i_rx_frame.runt || i_rx_frame.fcs_err);
   wire        act       = is_pause && addr_hit && proc_en && !bad_frame;
   // forwarding only picks the client path; act is computed without it
   wire        drop_hit  = is_pause && addr_hit && (!proc_en || !fwd_en);
   wire [`PFC_NQ-1:0] rx_classes = prio_mode ? i_rx_frame.class_en
                                             : {{(`PFC_NQ-1){1'b0}}, 1'b1};
   wire        tx_obeys  = prio_mode || honour;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rx_fwd  <= 1'b0;
         o_rx_drop <= 1'b0;
      end else begin
         o_rx_fwd  <= i_rx_frame.valid && !drop_hit;
         o_rx_drop <= i_rx_frame.valid && drop_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pause timers per class
   logic [15:0]        quanta_left_q [`PFC_NQ];
   logic [2:0]         sub_cnt_q     [`PFC_NQ];
   logic [`PFC_NQ-1:0] match_q;
   logic [`PFC_NQ-1:0] paused_q;

   for (genvar c = 0; c < `PFC_NQ; c++) begin : g_timer
      wire [15:0] rx_q  = time_of(i_rx_frame.times, c);
      wire        load  = act && rx_classes[c];
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            quanta_left_q[c] <= 16'h0000;
            sub_cnt_q[c]     <= 3'h0;
            match_q[c]       <= 1'b0;
         end else if (load) begin
            quanta_left_q[c] <= rx_q;
            sub_cnt_q[c]     <= 3'(`QUANTUM_CYC - 1);
            match_q[c]       <= (rx_q != 16'h0000);
         end else if (quanta_left_q[c] != 16'h0000) begin
            // one quantum of 512 bit times at the datapath width
            if (sub_cnt_q[c] == 3'h0) begin
               sub_cnt_q[c]     <= 3'(`QUANTUM_CYC - 1);
               quanta_left_q[c] <= quanta_left_q[c] - 16'h0001;
               match_q[c]       <= (quanta_left_q[c] != 16'h0001);
            end else begin
               sub_cnt_q[c] <= sub_cnt_q[c] - 3'h1;
            end
         end
      end
   end

   // stall takes effect only between frames; the frame in flight finishes
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         paused_q <= '0;
      end else begin
         paused_q <= match_q & (paused_q | {`PFC_NQ{!i_tx_in_frame}})
                     & {`PFC_NQ{tx_obeys}};
      end
   end
   assign o_pause_match = match_q;
   assign o_tx_paused   = paused_q;

   ////////////////////////////////////////////////////////////////////////////
   // read port
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (i_addr)
         `OFF_DADDR_LOW:   rd_mux = daddr_low_q;
         `OFF_DADDR_HIGH:  rd_mux = {16'h0000, daddr_high_q};
         `OFF_CTRL:        rd_mux = ctrl_q;
         `OFF_TX_CLASS_EN: rd_mux = {24'h0, class_en_q};
         `OFF_QUANTA:      rd_mux = {16'h0000, quanta_q};
         `OFF_HOLDOFF:     rd_mux = {16'h0000, holdoff_q};
         `OFF_STATUS:      rd_mux = {16'h0000, paused_q, match_q};
         default:          rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 32'h0000_0000;
      end else begin
         o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
      end
   end
endmodule

/* File: pause_fc_defines.svh */
// register offsets, field positions, reset values and timing counts of the pause block
`ifndef PAUSE_FC_DEFINES_SVH
`define PAUSE_FC_DEFINES_SVH
`define PFC_NQ              8
`define PFC_ADDR_W          12
`define OFF_DADDR_LOW       12'h707
`define OFF_DADDR_HIGH      12'h708
`define OFF_CTRL            12'h709
`define OFF_TX_CLASS_EN     12'h70A
`define OFF_QUANTA          12'h70B
`define OFF_HOLDOFF         12'h70C
`define OFF_STATUS          12'h70D
`define BIT_PROC_EN         0
`define BIT_FWD_EN          1
`define BIT_HONOUR          2
`define BIT_PRIO_MODE       3
`define BIT_RETX_EN         4
`define CTRL_RESET          32'h0000_0015
`define PAUSE_ETYPE         16'h8808
`define OPC_STD             16'h0001
`define OPC_PFC             16'h0101
`define MCAST_PAUSE_DA      48'h0180_C200_0001
`define QUANTUM_BITS        512
`define DATAPATH_BITS       64
`define QUANTUM_CYC         (`QUANTUM_BITS / `DATAPATH_BITS)
`define QUANTA_RESET        16'hFFFF
`define HOLDOFF_RESET       16'h7FFF
`endif

/* File: pause_fc_pkg.sv */
// types shared by the pause flow-control block
package pause_fc_pkg;
   typedef struct packed {
      logic        valid;
      logic [47:0] dest_addr;
      logic [15:0] ether_type;
      logic [15:0] opcode;
      logic [7:0]  class_en;
      logic [127:0] times;
      logic        runt;
      logic        fcs_err;
   } rx_ctrl_frame_s;
   typedef struct packed {
      logic        valid;
      logic        xon;
      logic [7:0]  class_vec;
      logic [15:0] quanta;
   } tx_pause_req_s;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_WAIT = 3'b010,
      TX_SEND = 3'b100
   } tx_gen_state_e;
endpackage

/* File: pause_fc_asserts.sv */
// concurrent checks on the ports of the pause flow-control block
`timescale 1ns/10ps
`include "pause_fc_defines.svh"
module pause_fc_asserts
   import pause_fc_pkg::*;
(
   input wire logic               i_sys_clk,
   input wire logic               i_rstn,
   input wire rx_ctrl_frame_s     i_rx_frame,
   input wire logic               i_tx_in_frame,
   input wire logic               o_rx_fwd,
   input wire logic               o_rx_drop,
   input wire logic [`PFC_NQ-1:0] o_pause_match,
   input wire logic [`PFC_NQ-1:0] o_tx_paused,
   input wire tx_pause_req_s      o_tx_pause_req
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);
   property p_rst_clear; $rose(i_rstn) |-> o_pause_match == '0 && o_tx_paused == '0; endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("pause state after reset");
   property p_verdict; i_rx_frame.valid |=> o_rx_fwd != o_rx_drop; endproperty
   a_verdict: assert property (p_verdict) else $error("no single verdict");
   property p_plain; i_rx_frame.valid && i_rx_frame.ether_type != `PAUSE_ETYPE |=> o_rx_fwd;
   endproperty
   a_plain: assert property (p_plain) else $error("plain frame withheld");
   property p_cause; |(o_pause_match & ~$past(o_pause_match)) |-> $past(i_rx_frame.valid);
   endproperty
   a_cause: assert property (p_cause) else $error("match without frame");
   property p_idle; |(o_tx_paused & ~$past(o_tx_paused)) |-> !$past(i_tx_in_frame); endproperty
   a_idle: assert property (p_idle) else $error("stall inside frame");
   property p_stall; (o_tx_paused & ~(o_pause_match | $past(o_pause_match))) == '0; endproperty
   a_stall: assert property (p_stall) else $error("stall without match");
   property p_pulse; o_tx_pause_req.valid |=> !o_tx_pause_req.valid; endproperty
   a_pulse: assert property (p_pulse) else $error("request longer than one cycle");
   property p_xon; o_tx_pause_req.valid && o_tx_pause_req.xon |-> o_tx_pause_req.quanta == '0;
   endproperty
   a_xon: assert property (p_xon) else $error("resume with quanta");
endmodule
bind mac_pause_flow_control pause_fc_asserts u_asserts (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
   .i_rx_frame(i_rx_frame), .i_tx_in_frame(i_tx_in_frame), .o_rx_fwd(o_rx_fwd),
   .o_rx_drop(o_rx_drop), .o_pause_match(o_pause_match), .o_tx_paused(o_tx_paused),
   .o_tx_pause_req(o_tx_pause_req));

/* File: link_partner.sv */
// far-side model: received frame headers and transmit activity
`timescale 1ns/10ps
module link_partner
   import pause_fc_pkg::*;
(
   input  wire logic      i_sys_clk,
   output rx_ctrl_frame_s o_frame,
   output logic           o_tx_in_frame
);
   initial begin
      o_frame = '0;
      o_tx_in_frame = 1'b0;
   end
   // fields are inverted once the frame is gone, so a stale header never passes for a live one
   task automatic send(input rx_ctrl_frame_s f);
      @(posedge i_sys_clk);
      o_frame <= f;
      @(posedge i_sys_clk);
      o_frame <= {1'b0, ~f[$bits(f)-2:0]};
   endtask
   task automatic burst(input int n);
      @(posedge i_sys_clk);
      o_tx_in_frame <= 1'b1;
      repeat (n) @(posedge i_sys_clk);
      o_tx_in_frame <= 1'b0;
   endtask
endmodule

/* File: tb.sv */
// self-checking bench of the pause flow-control block
`timescale 1ns/10ps
`include "pause_fc_defines.svh"
module tb;
   import pause_fc_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, fwd_o, drop_o, busy;
   logic [11:0] addr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [7:0]  ins = '0, match, paused;
   logic [47:0] da;
   rx_ctrl_frame_s frm;
   tx_pause_req_s  req;
   int bad_count = 0, cmp_count = 0;
   bit proc = 1, fwd = 0, prio = 0;
   always #5 clk = ~clk;
   mac_pause_flow_control dut (.i_sys_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pause_insert(ins), .i_rx_frame(frm),
      .i_tx_in_frame(busy), .o_rx_fwd(fwd_o), .o_rx_drop(drop_o), .o_pause_match(match),
      .o_tx_paused(paused), .o_tx_pause_req(req));
   link_partner lp (.i_sys_clk(clk), .o_frame(frm), .o_tx_in_frame(busy));
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // expected {forward, drop, match} of one frame under the current settings
   function automatic logic [9:0] model(input rx_ctrl_frame_s f);
      logic hit, pz, act;
      logic [7:0] m;
      hit = f.dest_addr == da || f.dest_addr == `MCAST_PAUSE_DA;
      pz = f.ether_type == `PAUSE_ETYPE && f.opcode == (prio ? `OPC_PFC : `OPC_STD);
      act = proc && pz && hit && !(!prio && (f.runt || f.fcs_err));
      m = '0;
      for (int n = 0; n < 8; n++) begin
         if ((prio ? f.class_en[n] : n == 0) && f.times[16*n +: 16] != '0)
            m[n] = act;
      end
      return {!(pz && hit && !(proc && fwd)), pz && hit && !(proc && fwd), m};
   endfunction
   task automatic rx(input logic [47:0] a, input logic [15:0] et, input logic [7:0] ce,
                     input logic [15:0] q, input logic bad);
      rx_ctrl_frame_s f;
      f = '{1'b1, a, et, prio ? `OPC_PFC : `OPC_STD, ce, {8{q}}, bad, bad};
      lp.send(f);
      #1 chk({fwd_o, drop_o, match}, model(f));
   endtask
   task automatic wait_req(input logic [25:0] e);
      int n;
      n = 0;
      while (req.valid !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1 n++;
      end
      chk({req.valid, req.xon, req.class_vec, req.quanta}, e);
      @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      end_of_test();
   end
   initial begin
      logic [47:0] a;
      logic [15:0] e, q;
      void'($urandom(32'h82D3828B));
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(`OFF_CTRL, `CTRL_RESET);
      rd_reg(`OFF_TX_CLASS_EN, 32'h0000_00FF);
      rd_reg(12'h7FF, 32'h0000_0000);
      da = {16'($urandom), $urandom};
      wr_reg(`OFF_DADDR_LOW, da[31:0]);
      wr_reg(`OFF_DADDR_HIGH, {16'h0000, da[47:32]});
      rd_reg(`OFF_DADDR_HIGH, {16'h0000, da[47:32]});
      rx(da, `PAUSE_ETYPE, 8'h01, 16'h0001, 1'b0);
      repeat (7) @(posedge clk);
      #1 chk(match[0], 1'b1);
      @(posedge clk);
      #1 chk(match[0], 1'b0);
      for (int c = 0; c < 8; c++) begin
         {proc, fwd, prio} = c[2:0];
         wr_reg(`OFF_CTRL, {27'h0, 1'b1, prio, 1'b1, fwd, proc});
         for (int k = 0; k < 5; k++) begin
            a = (k == 1) ? ~da : ((k == 2) ? `MCAST_PAUSE_DA : da);
            e = (k == 4) ? 16'h0800 : `PAUSE_ETYPE;
            q = 16'($urandom_range(3, 1));
            rx(a, e, 8'($urandom), q, k == 3);
            repeat (30) @(posedge clk);
         end
      end
      {proc, fwd, prio} = 3'b100;
      wr_reg(`OFF_CTRL, 32'h0000_0011);
      rx(da, `PAUSE_ETYPE, 8'h01, 16'h0004, 1'b0);
      repeat (3) @(posedge clk);
      #1 chk(paused, 8'h00);
      // let the unheeded pause run out, or re-enabling honour would stall at once
      repeat (40) @(posedge clk);
      wr_reg(`OFF_CTRL, `CTRL_RESET);
      fork
         lp.burst(6);
         rx(da, `PAUSE_ETYPE, 8'h01, 16'h0010, 1'b0);
      join
      #1 chk(paused[0], 1'b0);
      repeat (8) @(posedge clk);
      #1 chk(paused[0], 1'b1);
      rx(da, `PAUSE_ETYPE, 8'h01, 16'h0000, 1'b0);
      // class 7 is disabled so only class 0 may show up in the requests
      wr_reg(`OFF_TX_CLASS_EN, 32'h0000_007F);
      wr_reg(`OFF_HOLDOFF, 32'h0000_0028);
      ins <= 8'h81;
      wait_req({2'b10, 8'h01, `QUANTA_RESET});
      wait_req({2'b10, 8'h01, `QUANTA_RESET});
      ins <= 8'h00;
      wait_req({2'b11, 8'h01, 16'h0000});
      end_of_test();
   end
endmodule
